// File: src/wai_pkg.sv
package wai_pkg;
    // register offsets on the serial slave register port
    localparam logic [7:0] FLAG_ADDR = 8'h02;
    localparam logic [7:0] QUALITY_ADDR = 8'h04;
    localparam logic [7:0] LOST_ADDR = 8'h05;
    localparam logic [7:0] WARN_ADDR = 8'h37;
    localparam logic [7:0] ERROR_ADDR = 8'h38;
    localparam logic [7:0] SETUP_ADDR = 8'h53;

    // bit positions shared by the flag and setup registers
    localparam int POLARITY_BIT = 7;
    localparam int BROKEN_BIT = 6;
    localparam int POOR_BIT = 5;
    localparam int DONE_BIT = 4;
    localparam int PIN_BIT = 3;
    localparam int LOSS_BIT = 2;
    localparam int WAKE_BIT = 1;

    // implemented bits; bit 0 of both and bit 7 of the flags stay zero
    localparam logic [7:0] FLAG_MASK = 8'h7e;
    localparam logic [7:0] SETUP_MASK = 8'hfe;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // link monitoring windows, in frames, and count ceiling
    localparam int QUALITY_FRAMES = 14;
    localparam int LOSS_FRAMES = 32;
    localparam logic [7:0] COUNT_MAX = 8'hff;
endpackage

// File: src/wai_loss_window.sv
`timescale 1ns/10ps
// counts lost packets over back-to-back windows of FRAMES frames
module wai_loss_window #(
    parameter int FRAMES = 14
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic frame_tick,
    input wire logic packet_lost,
    output logic [7:0] count_reg,
    output logic update_reg
);
    localparam int FW = $clog2(FRAMES + 1);
    localparam logic [FW-1:0] LAST_FRAME = FW'(FRAMES - 1);

    logic [FW-1:0] frame_reg;
    logic [FW-1:0] frame_next;
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic [7:0] count_next;
    logic update_next;

    // a loss in the closing frame still belongs to the closing window
    always_comb begin
        logic [7:0] acc_now;
        acc_now = acc_reg;
        if (packet_lost && acc_reg != wai_pkg::COUNT_MAX) begin
            acc_now = acc_reg + 8'h01;
        end
        frame_next = frame_reg;
        acc_next = acc_now;
        count_next = count_reg;
        update_next = 1'b0;
        if (frame_tick) begin
            if (frame_reg == LAST_FRAME) begin
                frame_next = '0;
                acc_next = wai_pkg::ZERO_BYTE;
                count_next = acc_now;
                update_next = 1'b1;
            end else begin
                frame_next = frame_reg + FW'(1);
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frame_reg <= '0;
            acc_reg <= wai_pkg::ZERO_BYTE;
            count_reg <= wai_pkg::ZERO_BYTE;
            update_reg <= 1'b0;
        end else if (ce) begin
            frame_reg <= frame_next;
            acc_reg <= acc_next;
            count_reg <= count_next;
            update_reg <= update_next;
        end
    end
endmodule

// File: src/wai_irq_unit.sv
`timescale 1ns/10ps
// Notes on behaviour
// - setup bit 7 one gives an active-high pin, zero active-low.
// - a raised interrupt holds the pin until its flag is written one.
// - writing 7f to the flag register clears every flag.
// - reading the flag register returns it, then clears flags and pin.
// - flag 6 marks a broken link, gated by enable bit 6.
// - flag 5 sets when quality count <= warning threshold; enable 5.
// - flag 4 sets when any remote command or commit completes; enable 4.
// - flag 3 marks remote pin change, or receiver port low nibble change when a slave interface is present.
// - pin change follows far input pins or receiver output pins by role.
// - flag 2 sets when lost count >= error threshold; enable 2.
// - flag 1 marks wakeup from power down; enable 1.
// - outside wakeup mode, only enabled flags may make the pin active.
// - pin always driven as transmitter; receiver needs a slave interface.
// - flags and setup are local; events drive only this pin.
// - wakeup enable suppresses every other source on the pin.
// - with wakeup enabled the pin shows the power state.
// - poor quality and transfer done exist only as transmitter.
// - quality count is 255 minus losses in the last 14-frame window.
// - lost count is packets lost in the last 32-frame window.
module wai_irq_unit #(
    parameter int QUALITY_FRAMES = wai_pkg::QUALITY_FRAMES,
    parameter int LOSS_FRAMES = wai_pkg::LOSS_FRAMES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic transmitter_role_pin,
    input wire logic slave_if_pin,
    input wire logic powered_up_pin,
    input wire logic link_broken,
    input wire logic frame_tick,
    input wire logic packet_lost,
    input wire logic packet_lost_final,
    input wire logic remote_execute_done,
    input wire logic transmitter_commit_done,
    input wire logic link_commit_done,
    input wire logic receiver_commit_done,
    input wire logic [3:0] remote_input_pins,
    input wire logic [3:0] receiver_port_value,
    input wire logic wakeup_event,
    output logic irq_out,
    output logic irq_oe
);
    // pin synchronisers
    logic [2:0] pins_meta_reg;
    logic [2:0] pins_sync_reg;
    logic tx_role;
    logic slave_if;
    logic powered_up;

    // register state
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] setup_reg;
    logic [7:0] setup_next;
    logic [7:0] warn_reg;
    logic [7:0] warn_next;
    logic [7:0] error_reg;
    logic [7:0] error_next;
    logic [3:0] watch_reg;
    logic [3:0] watch_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic active_reg;
    logic active_next;
    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;

    // event terms
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    logic [3:0] watched;
    logic [7:0] quality_loss;
    logic [7:0] lost_count;
    logic [7:0] quality_count;
    logic quality_update;
    logic lost_update;
    logic flag_wr;
    logic flag_rd;

    assign tx_role = pins_sync_reg[0];
    assign slave_if = pins_sync_reg[1];
    assign powered_up = pins_sync_reg[2];
    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign irq_out = out_reg;
    assign irq_oe = oe_reg;

    // role and power straps come from pins, two stages before use
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pins_meta_reg <= 3'h0;
            pins_sync_reg <= 3'h0;
        end else if (ce) begin
            pins_meta_reg <= {powered_up_pin, slave_if_pin,
                transmitter_role_pin};
            pins_sync_reg <= pins_meta_reg;
        end
    end

    // window counters: every lost packet for quality, final losses for errors
    wai_loss_window #(
        .FRAMES(QUALITY_FRAMES)
    ) u_quality_window (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .frame_tick(frame_tick),
        .packet_lost(packet_lost),
        .count_reg(quality_loss),
        .update_reg(quality_update)
    );

    wai_loss_window #(
        .FRAMES(LOSS_FRAMES)
    ) u_lost_window (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .frame_tick(frame_tick),
        .packet_lost(packet_lost_final),
        .count_reg(lost_count),
        .update_reg(lost_update)
    );

    // 255 means a clean window
    assign quality_count = wai_pkg::COUNT_MAX - quality_loss;
    assign flag_wr = reg_wr && reg_addr == wai_pkg::FLAG_ADDR;
    assign flag_rd = reg_rd && reg_addr == wai_pkg::FLAG_ADDR;
    // source of the pin-change flag depends on role
    assign watched = tx_role ? remote_input_pins : receiver_port_value;

    // hardware set terms; quality and commit sources exist only as tx
    always_comb begin
        set_bits = wai_pkg::ZERO_BYTE;
        set_bits[wai_pkg::BROKEN_BIT] = link_broken;
        set_bits[wai_pkg::POOR_BIT] = tx_role && quality_update
            && quality_count <= warn_reg;
        set_bits[wai_pkg::DONE_BIT] = tx_role && (remote_execute_done
            || transmitter_commit_done || link_commit_done
            || receiver_commit_done);
        set_bits[wai_pkg::PIN_BIT] = (tx_role || slave_if)
            && watched != watch_reg;
        set_bits[wai_pkg::LOSS_BIT] = lost_update
            && lost_count >= error_reg;
        set_bits[wai_pkg::WAKE_BIT] = wakeup_event;
    end

    // clear terms: write-one per bit, or a read empties all
    always_comb begin
        clr_bits = wai_pkg::ZERO_BYTE;
        if (flag_wr) begin
            clr_bits = reg_wdata;
        end
        if (flag_rd) begin
            clr_bits = wai_pkg::FLAG_MASK;
        end
    end

    // register writes; set beats clear so no event is lost
    always_comb begin
        flags_next = ((flags_reg & ~clr_bits) | set_bits)
            & wai_pkg::FLAG_MASK;
        setup_next = setup_reg;
        warn_next = warn_reg;
        error_next = error_reg;
        watch_next = watched;
        if (reg_wr) begin
            case (reg_addr)
                wai_pkg::SETUP_ADDR: begin
                    setup_next = reg_wdata & wai_pkg::SETUP_MASK;
                end
                wai_pkg::WARN_ADDR: begin
                    warn_next = reg_wdata;
                end
                wai_pkg::ERROR_ADDR: begin
                    error_next = reg_wdata;
                end
                default: begin
                    setup_next = setup_reg;
                end
            endcase
        end
    end

    // read port; data shows the flags as they were before the clear
    always_comb begin
        rvalid_next = reg_rd;
        rdata_next = wai_pkg::ZERO_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                wai_pkg::FLAG_ADDR: rdata_next = flags_reg;
                wai_pkg::QUALITY_ADDR: rdata_next = quality_count;
                wai_pkg::LOST_ADDR: rdata_next = lost_count;
                wai_pkg::WARN_ADDR: rdata_next = warn_reg;
                wai_pkg::ERROR_ADDR: rdata_next = error_reg;
                wai_pkg::SETUP_ADDR: rdata_next = setup_reg;
                default: rdata_next = wai_pkg::ZERO_BYTE;
            endcase
        end
    end

    // pin drive from local state only; wakeup mode mirrors power
    always_comb begin
        if (setup_reg[wai_pkg::WAKE_BIT]) begin
            active_next = powered_up;
        end else begin
            active_next = |(flags_next & setup_reg
                & wai_pkg::FLAG_MASK);
        end
        out_next = active_next
            ~^ setup_reg[wai_pkg::POLARITY_BIT];
        oe_next = tx_role || slave_if;
    end

    // inactive level at reset is high, since polarity resets to low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags_reg <= wai_pkg::REG_RESET;
            setup_reg <= wai_pkg::REG_RESET;
            warn_reg <= wai_pkg::REG_RESET;
            error_reg <= wai_pkg::REG_RESET;
            watch_reg <= 4'h0;
            rdata_reg <= wai_pkg::ZERO_BYTE;
            rvalid_reg <= 1'b0;
            active_reg <= 1'b0;
            out_reg <= 1'b1;
            oe_reg <= 1'b0;
        end else if (ce) begin
            flags_reg <= flags_next;
            setup_reg <= setup_next;
            warn_reg <= warn_next;
            error_reg <= error_next;
            watch_reg <= watch_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            active_reg <= active_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    a_irq_polarity: assert property (
        @(posedge clock) disable iff (rst)
        ce |=> out_reg == (active_reg ~^ setup_reg[wai_pkg::POLARITY_BIT])
            || $past(reg_wr))
        else $error("irq level does not match polarity");

    a_flag_holds: assert property (
        @(posedge clock) disable iff (rst)
        ce && !flag_wr && !flag_rd |=> (flags_reg & $past(flags_reg))
            == $past(flags_reg))
        else $error("flag dropped without a clear");

    a_clear_all: assert property (
        @(posedge clock) disable iff (rst)
        ce && flag_wr && reg_wdata == 8'h7f && set_bits == 8'h00
        |=> flags_reg == 8'h00)
        else $error("write of 7f left a flag set");

    a_read_clears: assert property (
        @(posedge clock) disable iff (rst)
        ce && flag_rd && set_bits == 8'h00 |=> reg_rvalid
            && reg_rdata == $past(flags_reg) && flags_reg == 8'h00)
        else $error("flag read did not return and clear");

    a_broken_sets: assert property (
        @(posedge clock) disable iff (rst)
        ce && link_broken |=> flags_reg[wai_pkg::BROKEN_BIT])
        else $error("link broken event not flagged");

    a_done_sets: assert property (
        @(posedge clock) disable iff (rst)
        ce && tx_role && link_commit_done |=> flags_reg[wai_pkg::DONE_BIT])
        else $error("transfer done not flagged");

    a_rx_no_poor: assert property (
        @(posedge clock) disable iff (rst)
        ce && !tx_role && !flags_reg[wai_pkg::POOR_BIT]
        |=> !flags_reg[wai_pkg::POOR_BIT])
        else $error("poor quality flagged in receiver role");

    a_enable_gate: assert property (
        @(posedge clock) disable iff (rst)
        ce && !setup_reg[wai_pkg::WAKE_BIT] && $stable(setup_reg)
        && (flags_reg & setup_reg & wai_pkg::FLAG_MASK) == 8'h00
        && set_bits == 8'h00 |=> !active_reg)
        else $error("irq active with no enabled flag");

    a_wake_power: assert property (
        @(posedge clock) disable iff (rst)
        ce && setup_reg[wai_pkg::WAKE_BIT] |=> active_reg == $past(powered_up))
        else $error("wakeup mode does not mirror power state");

    a_pin_present: assert property (
        @(posedge clock) disable iff (rst)
        ce |=> irq_oe == $past(tx_role || slave_if))
        else $error("irq enable does not follow role");
endmodule

// File: verification/wai_host.sv
`timescale 1ns/10ps
// register-port master standing in for the external microcontroller
module wai_host (
    input wire logic clock,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write strobe; data inverted after so stale data never helps
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    // one-cycle read strobe; answer taken only while rvalid stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clock, rst, tx_role, slave_if, powered;
    logic [8:0] ev;
    logic [3:0] remote_pins, port_value;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic reg_wr, reg_rd, reg_rvalid, irq_out, irq_oe, ce;
    int err_total, samples_checked, cycles;

    // 8 ns clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // short windows keep the link counts quick to exercise
    wai_irq_unit #(.QUALITY_FRAMES(3), .LOSS_FRAMES(4)) uut (
        .clock(clock), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .transmitter_role_pin(tx_role), .slave_if_pin(slave_if),
        .powered_up_pin(powered), .link_broken(ev[0]),
        .frame_tick(ev[8]), .packet_lost(ev[1]),
        .packet_lost_final(ev[2]), .remote_execute_done(ev[3]),
        .transmitter_commit_done(ev[4]), .link_commit_done(ev[5]),
        .receiver_commit_done(ev[6]),
        .remote_input_pins(remote_pins),
        .receiver_port_value(port_value), .wakeup_event(ev[7]),
        .irq_out(irq_out), .irq_oe(irq_oe)
    );

    wai_host host (
        .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rd_val);
        check(rd_val, exp);
    endtask

    // event inputs are one-cycle pulses
    task automatic pulse(input int i);
        @(posedge clock);
        #1;
        ev[i] = 1'b1;
        @(posedge clock);
        #1;
        ev[i] = 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard, well above the roughly 160 cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        tx_role = 1'b1;
        slave_if = 1'b0;
        powered = 1'b1;
        ev = '0;
        remote_pins = 4'h0;
        port_value = 4'h0;
        err_total = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (20) @(posedge clock);
        #1;
        rst = 1'b0;
        settle(3);
        // reset state, unmapped read, clear-all
        check({7'h00, irq_oe}, 8'h01);
        host.wr(8'h02, 8'h7f);
        rd_chk(8'h53, 8'h00);
        rd_chk(8'h10, 8'h00);
        rd_chk(8'h02, 8'h00);
        $display("test reset done");
        // broken link, active-high pin, held until write-one
        host.wr(8'h53, 8'hc0);
        settle(1);
        check({7'h00, irq_out}, 8'h00);
        pulse(0);
        settle(1);
        check({7'h00, irq_out}, 8'h01);
        settle(5);
        check({7'h00, irq_out}, 8'h01);
        host.wr(8'h02, 8'h40);
        settle(1);
        check({7'h00, irq_out}, 8'h00);
        host.wr(8'h53, 8'h80);
        pulse(0);
        settle(1);
        check({7'h00, irq_out}, 8'h00);
        rd_chk(8'h02, 8'h40);
        rd_chk(8'h02, 8'h00);
        $display("test link broken done");
        // every completion source, active-low pin
        host.wr(8'h53, 8'h10);
        for (int i = 3; i <= 6; i++) begin
            pulse(i);
            settle(1);
            check({7'h00, irq_out}, 8'h00);
            rd_chk(8'h02, 8'h10);
            settle(1);
            check({7'h00, irq_out}, 8'h01);
        end
        $display("test transfer done done");
        // pin change in both roles
        remote_pins = 4'h5;
        settle(2);
        rd_chk(8'h02, 8'h08);
        tx_role = 1'b0;
        settle(4);
        check({7'h00, irq_oe}, 8'h00);
        host.wr(8'h02, 8'h7f);
        pulse(3);
        port_value = 4'ha;
        settle(2);
        rd_chk(8'h02, 8'h00);
        slave_if = 1'b1;
        settle(4);
        check({7'h00, irq_oe}, 8'h01);
        host.wr(8'h02, 8'h7f);
        port_value = 4'h3;
        settle(2);
        rd_chk(8'h02, 8'h08);
        tx_role = 1'b1;
        slave_if = 1'b0;
        settle(4);
        host.wr(8'h02, 8'h7f);
        // a low clock enable must let an event pulse pass unseen
        ce = 1'b0;
        pulse(0);
        ce = 1'b1;
        rd_chk(8'h02, 8'h00);
        $display("test pin change done");
        // link windows at threshold boundaries
        host.wr(8'h37, 8'hfe);
        host.wr(8'h38, 8'h02);
        pulse(1);
        pulse(2);
        pulse(2);
        repeat (4) pulse(8);
        settle(2);
        rd_chk(8'h04, 8'hfe);
        rd_chk(8'h05, 8'h02);
        rd_chk(8'h02, 8'h24);
        $display("test link windows done");
        // wakeup enable makes the pin show power state only
        host.wr(8'h53, 8'hc2);
        pulse(0);
        pulse(7);
        settle(4);
        check({7'h00, irq_out}, 8'h01);
        powered = 1'b0;
        settle(5);
        check({7'h00, irq_out}, 8'h00);
        rd_chk(8'h02, 8'h42);
        powered = 1'b1;
        $display("test wakeup done");
        test_done();
    end
endmodule
